/* File: srx_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - port enable claims the clock pin in sync master mode, else held disabled
// - single receive in sync master, self-clears
// - async continuous bit enables the receiver
// - framing flag follows head buffer character
module srx_core
    import srx_pkg::*;
(
    input  wire logic        pclk,        // system clock
    input  wire logic        presetn,     // async reset, low
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb access phase
    input  wire logic        pwrite,      // apb write
    input  wire logic [7:0]  paddr,       // apb byte address
    input  wire logic [31:0] pwdata,      // apb write data
    output logic [31:0]      prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error, unmapped address
    input  wire logic        rx_data_in,  // rx_data_pin input level
    output logic             rx_data_out, // rx_data_pin drive value
    output logic             rx_data_oe,  // rx_data_pin drive enable
    input  wire logic        tx_clock_in, // tx_clock_pin input level
    output logic             tx_clock_out,// tx_clock_pin drive value
    output logic             tx_clock_oe, // tx_clock_pin drive enable
    output logic             irq          // level interrupt
);
    typedef struct packed {
        logic [7:0]  rsc;      // control bits 7..3 used, flags held apart
        logic        sync;
        logic        master;
        logic [15:0] baud;
        logic [2:0]  istat;
        logic [2:0]  imask;
        srx_state_t  st;
        logic [3:0]  bitn;
        logic [8:0]  shf;
        logic        full;     // one-deep receive buffer
        logic [7:0]  buf_data;
        logic        buf_ninth;
        logic        buf_framing_error_flag;
        logic        overrun_error_flag;
        logic        ckprev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        ck_out;
        logic        ck_oe;
        logic        irq;
    } srx_core_st_t;
    srx_core_st_t s_q, s_d;

    logic bd_half;
    logic bd_tick;
    logic bd_clr;

    // register decode used by both read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_RSC) || (a == ADDR_RXDATA) || (a == ADDR_MODE) ||
                 (a == ADDR_ISTAT) || (a == ADDR_IMASK) || (a == ADDR_BAUD);
    endfunction

    srx_baud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (bd_clr),
        .period  (s_q.baud),
        .half    (bd_half),
        .tick    (bd_tick)
    );

    // shorthands for the enables; the state machine looks at these, the port-off force at the written enable bit
    logic en;
    logic async_on;
    logic sm_on;
    logic nine;
    logic acc;
    logic wr;
    logic rd;
    assign en       = s_q.rsc[BIT_PORT_EN];
    assign nine     = s_q.rsc[BIT_NINE];
    assign async_on = en && !s_q.sync && s_q.rsc[BIT_CONT];
    // continuous wins over single in synchronous master mode
    assign sm_on    = en && s_q.sync && s_q.master &&
                      (s_q.rsc[BIT_CONT] || s_q.rsc[BIT_SINGLE]);
    assign acc      = psel && penable && !s_q.pready;
    assign wr       = acc && pwrite && mapped(paddr);
    assign rd       = acc && !pwrite;
    assign bd_clr   = (s_q.st == SRX_IDLE);

    // receiver, buffer and register file in one next-state process
    always_comb begin
        logic       take;
        logic       keep;
        logic       is_last;
        logic [7:0] rdv;
        take      = 1'b0;
        keep      = 1'b0;
        is_last   = 1'b0;
        rdv       = 8'h00;
        s_d       = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.ckprev  = tx_clock_in;
        s_d.ck_oe   = en && s_q.sync && s_q.master;
        if (s_q.st == SRX_IDLE) begin
            s_d.ck_out = 1'b0;
        end

        // reads pop the buffer before any new byte lands
        if (rd && paddr == ADDR_RXDATA) begin
            s_d.full = 1'b0;
        end

        is_last = (s_q.bitn == (nine ? 4'h8 : 4'h7));
        case (s_q.st)
            SRX_IDLE: begin
                if (async_on && !rx_data_in) begin
                    s_d.st = SRX_START;
                end else if (sm_on) begin
                    s_d.st   = SRX_DATA;
                    s_d.bitn = 4'h0;
                end
            end
            SRX_START: begin
                if (!async_on) begin
                    s_d.st = SRX_IDLE;
                end else if (bd_half) begin
                    s_d.st   = rx_data_in ? SRX_IDLE : SRX_DATA;       // glitch rejects
                    s_d.bitn = 4'h0;
                end
            end
            SRX_DATA: begin
                if (!en || !(async_on || sm_on)) begin
                    s_d.st = SRX_IDLE;
                end else if (s_q.sync && bd_half) begin
                    s_d.ck_out = 1'b1;                                 // master clock high
                end else if (s_q.sync && bd_tick) begin
                    s_d.ck_out = 1'b0;
                    s_d.shf    = {rx_data_in, s_q.shf[8:1]};
                    s_d.bitn   = s_q.bitn + 4'h1;
                    if (is_last) begin
                        take     = 1'b1;
                        s_d.st   = SRX_IDLE;
                        s_d.rsc[BIT_SINGLE] = 1'b0;
                    end
                end else if (!s_q.sync && bd_half) begin
                    s_d.shf  = {rx_data_in, s_q.shf[8:1]};
                    s_d.bitn = s_q.bitn + 4'h1;
                    if (is_last) begin
                        s_d.st = SRX_STOP;
                    end
                end
            end
            SRX_STOP: begin
                if (!async_on) begin
                    s_d.st = SRX_IDLE;
                end else if (bd_half) begin
                    take   = 1'b1;
                    s_d.st = SRX_IDLE;
                end
            end
            default: s_d.st = SRX_IDLE;
        endcase

        // align a byte of eight bits down into the low lanes
        if (take) begin
            if (!nine) begin
                s_d.shf = {1'b0, s_d.shf[8:1]};
            end
            // filter in 9-bit async with address detect
            keep = s_q.sync || !nine || !s_q.rsc[BIT_ADDR] || s_d.shf[8];
            if (keep) begin
                if (s_d.full) begin
                    s_d.overrun_error_flag = 1'b1;
                    s_d.istat[EV_OVERRUN_ERROR_FLAG] = 1'b1;
                end else begin
                    s_d.full      = 1'b1;
                    s_d.buf_data  = s_d.shf[7:0];
                    s_d.buf_ninth = nine ? s_d.shf[8] : 1'b0;
                    s_d.buf_framing_error_flag  = !s_q.sync && !rx_data_in;
                    s_d.istat[EV_RXREADY] = 1'b1;
                    if (!s_q.sync && !rx_data_in) begin
                        s_d.istat[EV_FRAMING_ERROR_FLAG] = 1'b1;
                    end
                end
            end
        end

        // register writes; hardware sets of a clear event bit win over write-one clears
        if (wr) begin
            case (paddr)
                ADDR_RSC:   s_d.rsc[7:3] = pwdata[7:3];
                ADDR_MODE: begin
                    s_d.sync   = pwdata[0];
                    s_d.master = pwdata[1];
                end
                ADDR_ISTAT: s_d.istat = s_q.istat & ~pwdata[2:0] |
                                        (s_d.istat & ~s_q.istat);
                ADDR_IMASK: s_d.imask = pwdata[2:0];
                ADDR_BAUD:  s_d.baud  = pwdata[15:0];
                default:    s_d.rsc = s_d.rsc;
            endcase
        end
        // overrun clears only while continuous receive is off
        if (!s_d.rsc[BIT_CONT]) begin
            s_d.overrun_error_flag = 1'b0;
        end
        if (!s_d.rsc[BIT_PORT_EN]) begin
            s_d.st    = SRX_IDLE;
            s_d.ck_oe = 1'b0;
        end

        // read mux, one wait state
        rdv = {s_q.rsc[7:3], s_q.buf_framing_error_flag, s_q.overrun_error_flag, s_q.buf_ninth};
        if (acc) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !mapped(paddr);
            s_d.prdata  = 32'h0000_0000;
            case (paddr)
                ADDR_RSC:    s_d.prdata = {24'h000000, rdv};
                ADDR_RXDATA: s_d.prdata = {24'h000000, s_q.buf_data};
                ADDR_MODE:   s_d.prdata = {30'h0, s_q.master, s_q.sync};
                ADDR_ISTAT:  s_d.prdata = {29'h0, s_q.istat};
                ADDR_IMASK:  s_d.prdata = {29'h0, s_q.imask};
                ADDR_BAUD:   s_d.prdata = {16'h0000, s_q.baud};
                default:     s_d.prdata = 32'h0000_0000;
            endcase
        end
        s_d.irq = |(s_d.istat & s_d.imask);
    end

    // state register; reset leaves the receiver idle with the default control value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q      <= '0;
            s_q.rsc  <= RSC_RESET;
            s_q.baud <= BAUD_RESET;
            s_q.st   <= SRX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs taken from the state register so they never glitch
    assign prdata       = s_q.prdata;
    assign pready       = s_q.pready;
    assign pslverr      = s_q.pslverr;
    assign rx_data_out  = 1'b0;   // receive only; line is never driven here
    assign rx_data_oe   = 1'b0;
    assign tx_clock_out = s_q.ck_out;
    assign tx_clock_oe  = s_q.ck_oe;
    assign irq          = s_q.irq;

    // receiver control checks
    AST_DISABLED_NO_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.rsc[BIT_PORT_EN] |=> !tx_clock_oe) else $error("clock driven while off");
    AST_PORT_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !en |=> s_q.st == SRX_IDLE) else $error("receiver runs while port off");
    AST_CLK_OE_ON: assert property (@(posedge pclk) disable iff (!presetn)
        (en && s_q.sync && s_q.master && !wr) |=> tx_clock_oe)
        else $error("master clock pin not driven");
    AST_SINGLE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.st == SRX_DATA && s_q.sync && sm_on && bd_tick && !wr &&
         s_q.bitn == (nine ? 4'h8 : 4'h7))
        |=> !s_q.rsc[BIT_SINGLE]) else $error("single receive not cleared");
    AST_ASYNC_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.sync && !s_q.rsc[BIT_CONT] && !s_q.rsc[BIT_SINGLE]) ##1
        (!s_q.sync && !s_q.rsc[BIT_CONT] && !s_q.rsc[BIT_SINGLE])
        |-> s_q.st == SRX_IDLE) else $error("receiver runs while off");
    AST_ADDR_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.st == SRX_STOP && bd_half && async_on && nine && s_q.rsc[BIT_ADDR]
         && !s_q.shf[8] && !s_q.full) |=> !s_q.full) else $error("address filter");
    AST_ADDR_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.st == SRX_STOP && bd_half && async_on && nine && s_q.rsc[BIT_ADDR]
         && s_q.shf[8] && !s_q.full) |=> s_q.full) else $error("addressed byte lost");
    AST_FRAMING_ERROR_FLAG_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.full && !(rd && paddr == ADDR_RXDATA)) |=> $stable(s_q.buf_framing_error_flag))
        else $error("framing flag moved");
    AST_POP: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && paddr == ADDR_RXDATA && s_q.st == SRX_IDLE) |=> !s_q.full)
        else $error("read did not free the buffer");
    AST_OVERRUN_ERROR_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.rsc[BIT_CONT] |-> !s_q.overrun_error_flag) else $error("overrun held");
    AST_OVERRUN_ERROR_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.st == SRX_STOP && bd_half && async_on && s_q.full && !rd &&
         (!nine || !s_q.rsc[BIT_ADDR] || s_q.shf[8]) && !wr)
        |=> s_q.overrun_error_flag) else $error("overrun missed");
    // bus and interrupt checks
    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready) else $error("ready timing");
    AST_PSLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !mapped(paddr)) |=> pslverr)
        else $error("unmapped access not refused");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(s_q.istat & s_q.imask)) else $error("irq cause");
    // scenarios worth seeing
    COV_ASYNC_BYTE: cover property (@(posedge pclk) $rose(s_q.full) && !s_q.sync);
    COV_SYNC_BYTE: cover property (@(posedge pclk) $rose(s_q.full) && s_q.sync);
    COV_OVERRUN: cover property (@(posedge pclk) $rose(s_q.overrun_error_flag));
    COV_ADDR_DROP: cover property (@(posedge pclk) s_q.st == SRX_STOP && bd_half && async_on
        && nine && s_q.rsc[BIT_ADDR] && !s_q.shf[8]);
    COV_FRAMING: cover property (@(posedge pclk) $rose(s_q.buf_framing_error_flag));
endmodule // srx_core

/* File: srx_pkg.sv */
package srx_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_RSC    = 8'h00; // receive_status_control
    localparam logic [7:0] ADDR_RXDATA = 8'h04; // rx_data_register (read pops)
    localparam logic [7:0] ADDR_MODE   = 8'h08; // bit0 sync, bit1 master
    localparam logic [7:0] ADDR_ISTAT  = 8'h0c; // sticky events, write one to clear
    localparam logic [7:0] ADDR_IMASK  = 8'h10; // interrupt mask
    localparam logic [7:0] ADDR_BAUD   = 8'h14; // bit period in clocks minus one
    // field positions of receive_status_control
    localparam int BIT_PORT_EN = 7;
    localparam int BIT_NINE    = 6;
    localparam int BIT_SINGLE  = 5;
    localparam int BIT_CONT    = 4;
    localparam int BIT_ADDR    = 3;
    localparam int BIT_FRAMING_ERROR_FLAG    = 2;
    localparam int BIT_OVERRUN_ERROR_FLAG    = 1;
    localparam int BIT_NINTH   = 0;
    // interrupt event bits
    localparam int EV_RXREADY = 0;
    localparam int EV_FRAMING_ERROR_FLAG    = 1;
    localparam int EV_OVERRUN_ERROR_FLAG    = 2;
    // reset values
    localparam logic [7:0]  RSC_RESET  = 8'h00;
    localparam logic [15:0] BAUD_RESET = 16'h0003;
    localparam int          NBITS_MAX  = 9;
    typedef enum logic [1:0] {
        SRX_IDLE  = 2'b00,
        SRX_START = 2'b01,
        SRX_DATA  = 2'b11,
        SRX_STOP  = 2'b10
    } srx_state_t;
endpackage

/* File: srx_baud.sv */
`timescale 1ns/1ps
// bit-rate enable divider; restarts on clear so bit centres align to a start edge
module srx_baud
    import srx_pkg::*;
(
    input  wire logic        pclk,    // system clock
    input  wire logic        presetn, // async reset, low
    input  wire logic        clr,     // restart the period
    input  wire logic [15:0] period,  // clocks per bit minus one
    output logic             half,    // pulse at mid period
    output logic             tick     // pulse at end of period
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        half;
        logic        tick;
    } srx_baud_st_t;
    srx_baud_st_t s_q, s_d;

    // free counter with two strobes
    always_comb begin
        s_d      = s_q;
        s_d.half = 1'b0;
        s_d.tick = 1'b0;
        if (clr) begin
            s_d.cnt = 16'h0000;
        end else if (s_q.cnt >= period) begin
            s_d.cnt  = 16'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == {1'b0, period[15:1]}) begin
                s_d.half = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign half = s_q.half;
    assign tick = s_q.tick;
endmodule // srx_baud

/* File: srx_line_model.sv */
`timescale 1ns/1ps
// far-end sender: async frames on request, sync bits on the device clock
module srx_line_model (
    input  wire logic pclk, // system clock
    input  wire logic sck,  // tx_clock_pin level
    output logic      line  // rx_data_pin level
);
    logic [8:0] sbuf;
    int         sn = 0;
    logic       sck_d = 1'b1;
    initial line = 1'b1;
    // one async frame: start, n data bits lsb first, stop, idle gap
    task automatic send(input logic [8:0] d, input int n, input logic stp, input int p);
        @(posedge pclk) line <= 1'b0;
        repeat (p) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            line <= d[i];
            repeat (p) @(posedge pclk);
        end
        line <= stp; // a low stop bit is a deliberate framing fault
        repeat (p) @(posedge pclk);
        line <= 1'b1;
        repeat (2 * p) @(posedge pclk);
    endtask
    // arm the bits for a clocked transfer
    task automatic load(input logic [8:0] d, input int n);
        sbuf = d;
        sn   = n;
    endtask
    // change on the rising clock so data is steady at the falling one; toggle once spent
    always @(posedge pclk) begin
        sck_d <= sck;
        if (sck && !sck_d) begin
            line <= (sn > 0) ? sbuf[0] : ~line;
            sbuf <= sbuf >> 1;
            if (sn > 0) sn <= sn - 1;
        end
    end
endmodule // srx_line_model

/* File: srx_core_tb.sv */
`timescale 1ns/1ps
// apb driver notes expected answers, a monitor compares them as they appear
module srx_core_tb;
    import srx_pkg::*;
    localparam int P = int'(BAUD_RESET) + 1; // clocks per bit at the reset baud value
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] msk;
        logic        err;
    } srx_note_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rx_data_out, rx_data_oe, tx_clock_out, tx_clock_oe, irq;
    logic        line, rx_pin, ck_pin;
    srx_note_t   notes[$], nt;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    logic [8:0]  b, b2;
    // pin levels from all drivers; clock pin pulled up when released
    assign rx_pin = rx_data_oe ? rx_data_out : line;
    assign ck_pin = tx_clock_oe ? tx_clock_out : 1'b1;
    always #12.5 pclk = ~pclk;
    srx_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_data_in(rx_pin), .rx_data_out(rx_data_out),
        .rx_data_oe(rx_data_oe), .tx_clock_in(ck_pin), .tx_clock_out(tx_clock_out),
        .tx_clock_oe(tx_clock_oe), .irq(irq));
    srx_line_model u_line (.pclk(pclk), .sck(ck_pin), .line(line));
    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; the answer is judged by the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic [31:0] msk, input logic err);
        @(posedge pclk);
        notes.push_back('{exp, msk, err});
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        apb(1'b0, a, 32'h0, exp, msk, 1'b0);
    endtask
    // pin level is read after the wait, once the registered output has settled
    task automatic pin(input string what, input logic exp);
        repeat (2) @(posedge pclk);
        check(what, {31'h0, exp}, {31'h0, ((what == "irq") ? irq : tx_clock_oe)});
    endtask
    // monitor: take the oldest note whenever an answer is sampled
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            check("prdata", nt.val & nt.msk, prdata & nt.msk);
            check("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
        end
    end
    // hang guard, far above the length of the sequence
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'hd1ea));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, read-only flags, refused address
        rd(ADDR_RSC, {24'h0, RSC_RESET}, '1);
        rd(ADDR_BAUD, {16'h0, BAUD_RESET}, '1);
        rd(ADDR_ISTAT, 32'h0, '1);
        rd(ADDR_IMASK, 32'h0, '1);
        rd(ADDR_MODE, 32'h0, '1);
        apb(1'b0, 8'h18, 32'h0, 32'h0, '1, 1'b1);
        wr(ADDR_RSC, 32'hff);
        rd(ADDR_RSC, 32'hf8, '1);
        pin("tx_clock_oe", 1'b0);
        wr(ADDR_IMASK, 32'h7);
        // receiver off: port disabled, then continuous bit clear
        wr(ADDR_RSC, 32'h10);
        u_line.send(9'h0a5, 8, 1'b1, P);
        rd(ADDR_ISTAT, 32'h0, '1);
        wr(ADDR_RSC, 32'h80);
        u_line.send(9'h05a, 8, 1'b1, P);
        rd(ADDR_ISTAT, 32'h0, '1);
        wr(ADDR_RSC, 32'h90);
        for (int i = 0; i < 3; i++) begin
            b = 9'($urandom_range(255));
            u_line.send(b, 8, 1'b1, P);
            rd(ADDR_ISTAT, 32'h1, 32'h1);
            pin("irq", 1'b1);
            rd(ADDR_RXDATA, {23'h0, b}, 32'hff);
            wr(ADDR_ISTAT, 32'h7);
            pin("irq", 1'b0);
        end
        // framing fault, then cleared by the next good byte
        u_line.send(9'h0c3, 8, 1'b0, P);
        rd(ADDR_RSC, 32'h4, 32'h4);
        rd(ADDR_ISTAT, 32'h2, 32'h2);
        rd(ADDR_RXDATA, 32'hc3, 32'hff);
        u_line.send(9'h03c, 8, 1'b1, P);
        rd(ADDR_RSC, 32'h0, 32'h4);
        rd(ADDR_RXDATA, 32'h3c, 32'hff);
        // overrun: second byte into a full buffer, cleared with the continuous bit
        b  = 9'($urandom_range(255));
        b2 = 9'($urandom_range(255));
        u_line.send(b, 8, 1'b1, P);
        u_line.send(b2, 8, 1'b1, P);
        rd(ADDR_RSC, 32'h2, 32'h2);
        rd(ADDR_ISTAT, 32'h4, 32'h4);
        rd(ADDR_RXDATA, {23'h0, b}, 32'hff);
        wr(ADDR_RSC, 32'h80);
        rd(ADDR_RSC, 32'h80, 32'hf2);
        wr(ADDR_ISTAT, 32'h7);
        // address detect: ninth bit clear dropped, set accepted
        wr(ADDR_RSC, 32'hd8);
        u_line.send({1'b0, b2[7:0]}, 9, 1'b1, P);
        rd(ADDR_ISTAT, 32'h0, 32'h1);
        u_line.send({1'b1, b[7:0]}, 9, 1'b1, P);
        rd(ADDR_RSC, 32'hd9, 32'hff);
        rd(ADDR_RXDATA, {24'h0, b[7:0]}, 32'hff);
        wr(ADDR_RSC, 32'hd0);
        u_line.send({1'b0, b2[7:0]}, 9, 1'b1, P);
        rd(ADDR_RXDATA, {24'h0, b2[7:0]}, 32'hff);
        // sync master single reception clears its own enable
        wr(ADDR_RSC, 32'h0);
        wr(ADDR_MODE, 32'h3);
        b = 9'($urandom_range(255));
        u_line.load(b, 8);
        wr(ADDR_RSC, 32'ha0);
        pin("tx_clock_oe", 1'b1);
        repeat (12 * P + 20) @(posedge pclk);
        rd(ADDR_RSC, 32'h0, 32'h20);
        rd(ADDR_RXDATA, {23'h0, b}, 32'hff);
        // mid-run reset returns control, mode, event and baud registers to their reset values
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_RSC, {24'h0, RSC_RESET}, '1);
        rd(ADDR_MODE, 32'h0, '1);
        rd(ADDR_ISTAT, 32'h0, '1);
        rd(ADDR_BAUD, {16'h0, BAUD_RESET}, '1);
        pin("tx_clock_oe", 1'b0);
        complete_run();
    end
endmodule // srx_core_tb
